// ### verilog/vst_translator.sv
// Segment translator top: privilege stack, registered translation, shutdown flag.
// Assumes the core pipeline drives all inputs on clk_sys_i, one access a cycle.
`timescale 1ns/10ps
`default_nettype none

module vst_translator #(
    parameter bit EXTENDED_VARIANT = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire vst_pkg::vst_req_t req_i,
    input wire logic exception_i,
    input wire logic return_from_exception_instr_i,
    input wire logic cp_tb_wr_i,
    input wire logic cp_tb_rd_i,
    output vst_pkg::vst_rsp_t rsp_o,
    output logic [19:0] virtual_page_number_o,
    output logic user_mode_o,
    output logic translation_buffer_shutdown_flag_o,
    output logic [31:0] cp_tb_rdata_o,
    output logic cp_tb_ack_o
);

    // ------------------------------------------------------------------
    // Privilege stack
    // ------------------------------------------------------------------
    // Three levels: current, previous and old. An exception pushes kernel on
    // top; a return pops, refilling the oldest level with user state so a
    // deep return can never hand out kernel rights nobody saved.
    logic cur_user_q;
    logic prev_user_q;
    logic old_user_q;
    logic cur_user_d;
    logic prev_user_d;
    logic old_user_d;

    wire logic do_exc_w = exception_i;
    // An exception in the same cycle as a return wins: the fault is newer.
    wire logic do_rfe_w = return_from_exception_instr_i && !exception_i;

    assign cur_user_d = do_exc_w ? vst_pkg::MODE_KERNEL :
                        (do_rfe_w ? prev_user_q : cur_user_q);
    assign prev_user_d = do_exc_w ? cur_user_q :
                         (do_rfe_w ? old_user_q : prev_user_q);
    assign old_user_d = do_exc_w ? prev_user_q :
                        (do_rfe_w ? vst_pkg::MODE_USER : old_user_q);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur_user_q <= vst_pkg::MODE_RESET;
            prev_user_q <= vst_pkg::MODE_RESET;
            old_user_q <= vst_pkg::MODE_RESET;
        end else begin
            cur_user_q <= cur_user_d;
            prev_user_q <= prev_user_d;
            old_user_q <= old_user_d;
        end
    end

    assign user_mode_o = cur_user_q;

    // ------------------------------------------------------------------
    // Translation
    // ------------------------------------------------------------------
    // The access is translated with the state in force when it is issued;
    // a same-cycle exception affects the next access only.
    vst_pkg::vst_xlat_t xlat_w;

    vst_seg_decode u_seg_decode (
        .va_i(req_i.va),
        .user_mode_i(cur_user_q),
        .xlat_o(xlat_w)
    );

    vst_pkg::vst_rsp_t rsp_q;
    vst_pkg::vst_rsp_t rsp_d;
    logic [19:0] vpn_q;

    assign rsp_d.valid = req_i.valid;
    assign rsp_d.pa = xlat_w.pa;
    assign rsp_d.cacheable = xlat_w.cacheable;
    assign rsp_d.addr_err = xlat_w.addr_err;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rsp_q <= '0;
            vpn_q <= 20'h00000;
        end else begin
            rsp_q <= rsp_d;
            vpn_q <= req_i.va[vst_pkg::VPN_LSB +: vst_pkg::VPN_W];
        end
    end

    assign rsp_o = rsp_q;
    assign virtual_page_number_o = vpn_q;

    // ------------------------------------------------------------------
    // Shutdown flag and translation-buffer register stubs
    // ------------------------------------------------------------------
    // The flag is a constant per variant, held in a flop so that it is
    // defined from reset onward and read like any status bit.
    localparam logic TS_VALUE = EXTENDED_VARIANT ? vst_pkg::TB_SHUTDOWN_EXTENDED
                                                 : vst_pkg::TB_SHUTDOWN_BASE;
    logic ts_q;
    logic ack_q;
    logic [31:0] rdata_q;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ts_q <= TS_VALUE;
            ack_q <= 1'b0;
            rdata_q <= vst_pkg::TB_READ_VALUE;
        end else begin
            ts_q <= TS_VALUE;
            ack_q <= cp_tb_wr_i || cp_tb_rd_i;
            rdata_q <= vst_pkg::TB_READ_VALUE;
        end
    end

    // Writes are acknowledged and dropped; nothing here feeds the mapper.
    assign translation_buffer_shutdown_flag_o = ts_q;
    assign cp_tb_ack_o = ack_q;
    assign cp_tb_rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_VPN: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.valid |=> virtual_page_number_o == $past(req_i.va[31:12]))
        else $error("Page number output does not follow the issued address.");

    AST_RSP_VALID: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.valid |=> rsp_o.valid && (rsp_o.cacheable -> !rsp_o.addr_err))
        else $error("Answer missing or cacheable together with an error.");

    AST_USER_ERR: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && user_mode_o && req_i.va[31]) |=> rsp_o.addr_err && !rsp_o.cacheable)
        else $error("User access to the kernel half did not fault.");

    AST_USER_SEG_OPEN: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && !req_i.va[31]) |=> !rsp_o.addr_err && !rsp_o.cacheable)
        else $error("User segment access faulted or was marked cacheable.");

    AST_USER_MAP: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && !req_i.va[31]) |=>
            rsp_o.pa == {2'h1, $past(req_i.va[29:0])})
        else $error("User segment address not moved to the 01 region.");

    AST_KERNEL_USER_SAME: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && !user_mode_o && !req_i.va[31]) |=>
            rsp_o.pa[31:30] == 2'h1 && rsp_o.pa[29:0] == $past(req_i.va[29:0]))
        else $error("Kernel view of the user segment differs.");

    AST_CACHED: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && !user_mode_o && req_i.va[31:29] == 3'h4) |=>
            rsp_o.cacheable && rsp_o.pa == {3'h0, $past(req_i.va[28:0])})
        else $error("Cached kernel segment mapped or marked wrongly.");

    AST_UNCACHED: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && req_i.va[31:29] == 3'h5) |=>
            !rsp_o.cacheable && rsp_o.pa[28:0] == $past(req_i.va[28:0]))
        else $error("Uncached kernel segment marked cacheable or remapped.");

    AST_UNCACHED_TOP: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && !user_mode_o && req_i.va[31:29] == 3'h5) |=>
            rsp_o.pa[31:29] == 3'h0 && !rsp_o.addr_err)
        else $error("Uncached kernel segment top bits not cleared.");

    AST_MAPPED: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && !user_mode_o && req_i.va[31:30] == 2'h3) |=>
            rsp_o.pa == $past(req_i.va) && !rsp_o.addr_err && !rsp_o.cacheable)
        else $error("Mapped kernel segment not passed through.");

    AST_MAPPED_USER: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && user_mode_o && req_i.va[31:30] == 2'h3) |=> rsp_o.addr_err)
        else $error("Mapped kernel segment reached from user state.");

    AST_EXC_KERNEL: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        exception_i |=> !user_mode_o && prev_user_q == $past(user_mode_o))
        else $error("Exception did not enter kernel state and save the old one.");

    AST_RFE_RESTORE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (return_from_exception_instr_i && !exception_i) |=>
            user_mode_o == $past(prev_user_q) && old_user_q)
        else $error("Return did not restore the saved state.");

    AST_EXC_RFE_ROUND: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (exception_i && !return_from_exception_instr_i) ##1
            (!exception_i && !return_from_exception_instr_i) ##1
            (return_from_exception_instr_i && !exception_i) |=>
            user_mode_o == $past(user_mode_o, 3))
        else $error("Exception then return did not give back the original state.");

    AST_TS_FLAG: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        1'b1 |-> translation_buffer_shutdown_flag_o == !EXTENDED_VARIANT)
        else $error("Shutdown flag does not match the variant.");

    AST_TB_INERT: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (cp_tb_wr_i || cp_tb_rd_i) |=> cp_tb_ack_o && cp_tb_rdata_o == 32'h0000_0000
            && translation_buffer_shutdown_flag_o == $past(translation_buffer_shutdown_flag_o))
        else $error("Translation-buffer register access had an effect.");

    AST_TB_MAP_STABLE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (cp_tb_wr_i && req_i.valid && !user_mode_o && req_i.va[31:30] == 2'h3) |=>
            rsp_o.pa == $past(req_i.va))
        else $error("Register write disturbed the address mapping.");

    AST_SEG_TOP: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        req_i.valid |=> rsp_o.pa[28:0] == $past(req_i.va[28:0]))
        else $error("Bits below the segment field were altered.");

    AST_SEG_SELECT: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (req_i.valid && !user_mode_o) |=>
            rsp_o.cacheable == ($past(req_i.va[31:29]) == 3'h4))
        else $error("Cacheability not chosen by the segment bits.");

endmodule : vst_translator

`default_nettype wire

// ### verilog/vst_pkg.sv
// Shared constants and carriers for the virtual segment translator.
// Assumes one processor clock domain and a core that issues one access per cycle.
package vst_pkg;

    // ------------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int VPN_W = 20;
    localparam int VPN_LSB = 12;
    localparam int SEG_W = 3;
    localparam int SEG_LSB = 29;
    localparam int HI2_LSB = 30;

    // ------------------------------------------------------------------
    // Segment codes in the top address bits
    // ------------------------------------------------------------------
    localparam logic SEG_USER_MSB = 1'b0;
    localparam logic [2:0] SEG_CACHED_KERNEL = 3'h4;
    localparam logic [2:0] SEG_UNCACHED_KERNEL = 3'h5;
    localparam logic [1:0] SEG_MAPPED_KERNEL = 2'h3;
    localparam logic [2:0] SEG_KERNEL_PHYS_TOP = 3'h0;
    localparam logic [1:0] USER_PHYS_TOP = 2'h1;

    // ------------------------------------------------------------------
    // Privilege encoding and reset values
    // ------------------------------------------------------------------
    localparam logic MODE_USER = 1'b1;
    localparam logic MODE_KERNEL = 1'b0;
    localparam logic MODE_RESET = 1'h0;
    localparam logic TB_SHUTDOWN_BASE = 1'h1;
    localparam logic TB_SHUTDOWN_EXTENDED = 1'h0;
    localparam logic [31:0] TB_READ_VALUE = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] va;
    } vst_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] pa;
        logic cacheable;
        logic addr_err;
    } vst_xlat_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] pa;
        logic cacheable;
        logic addr_err;
    } vst_rsp_t;

endpackage : vst_pkg

// ### verilog/vst_seg_decode.sv
// Combinational segment decoder and address mapper, used unchanged by both variants.
// Assumes the caller registers the result; no state is held here.
`timescale 1ns/10ps
`default_nettype none

module vst_seg_decode (
    input wire logic [31:0] va_i,
    input wire logic user_mode_i,
    output vst_pkg::vst_xlat_t xlat_o
);

    // ------------------------------------------------------------------
    // Segment decode
    // ------------------------------------------------------------------
    wire logic [2:0] seg_w = va_i[vst_pkg::SEG_LSB +: vst_pkg::SEG_W];
    wire logic in_user_w = (va_i[31] == vst_pkg::SEG_USER_MSB);
    wire logic in_cached_w = (seg_w == vst_pkg::SEG_CACHED_KERNEL);
    wire logic in_uncached_w = (seg_w == vst_pkg::SEG_UNCACHED_KERNEL);
    wire logic in_mapped_w = (seg_w[2:1] == vst_pkg::SEG_MAPPED_KERNEL);
    wire logic in_direct_w = in_cached_w || in_uncached_w;

    // ------------------------------------------------------------------
    // Physical address forming
    // ------------------------------------------------------------------
    // Only the segment bits change; the low 29 or 30 bits always pass.
    wire logic [31:0] pa_user_w = {vst_pkg::USER_PHYS_TOP, va_i[29:0]};
    wire logic [31:0] pa_direct_w = {vst_pkg::SEG_KERNEL_PHYS_TOP, va_i[28:0]};

    // Kernel-half accesses from user state fault; the user half is open to both.
    wire logic fault_w = user_mode_i && (in_direct_w || in_mapped_w);

    assign xlat_o.pa = in_user_w ? pa_user_w :
                       (in_mapped_w ? va_i : pa_direct_w);
    // Only the cached kernel segment may ever live in cache.
    assign xlat_o.cacheable = in_cached_w && !fault_w;
    assign xlat_o.addr_err = fault_w;

endmodule : vst_seg_decode

`default_nettype wire

// ### tb/vst_core_model.sv
// Behavioural core pipeline that issues accesses and state events to the translator.
// Assumes the bench calls its task after reset release and samples at falling edges.
`timescale 1ns/10ps
`default_nettype none

module vst_core_model (
    input wire logic clk_i,
    output vst_pkg::vst_req_t req_o,
    output logic exception_o,
    output logic return_o,
    output logic cp_wr_o,
    output logic cp_rd_o
);
    initial begin
        req_o = '0;
        exception_o = 1'b0;
        return_o = 1'b0;
        cp_wr_o = 1'b0;
        cp_rd_o = 1'b0;
    end

    // -----------------------------------------------------------------
    // One issue cycle
    // -----------------------------------------------------------------
    // The idle address bus shows the inverse of the last address, so a
    // translator that latches while valid is low cannot pass by luck.
    task automatic step(input logic v, input logic [31:0] va, input logic [3:0] ev);
        @(negedge clk_i);
        req_o.valid = v;
        req_o.va = va;
        {exception_o, return_o, cp_wr_o, cp_rd_o} = ev;
        @(negedge clk_i);
        req_o.valid = 1'b0;
        req_o.va = ~va;
        {exception_o, return_o, cp_wr_o, cp_rd_o} = 4'h0;
    endtask : step
endmodule : vst_core_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the segment translator in its base variant.
// Assumes the core model issues all stimulus and results settle by the next falling edge.
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam int CYCLE_LIMIT = 2000;
    logic clk;
    logic resetn;
    vst_pkg::vst_req_t req;
    logic exc, ret, cp_wr, cp_rd;
    vst_pkg::vst_rsp_t rsp;
    logic [19:0] virtual_page_number;
    logic user_mode, shutdown, cp_ack;
    logic [31:0] cp_rdata;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    vst_core_model core (.clk_i(clk), .req_o(req), .exception_o(exc), .return_o(ret),
        .cp_wr_o(cp_wr), .cp_rd_o(cp_rd));

    vst_translator #(.EXTENDED_VARIANT(1'b0)) DUT (.clk_sys_i(clk), .resetn_i(resetn),
        .req_i(req), .exception_i(exc), .return_from_exception_instr_i(ret),
        .cp_tb_wr_i(cp_wr), .cp_tb_rd_i(cp_rd), .rsp_o(rsp), .virtual_page_number_o(virtual_page_number),
        .user_mode_o(user_mode), .translation_buffer_shutdown_flag_o(shutdown),
        .cp_tb_rdata_o(cp_rdata), .cp_tb_ack_o(cp_ack));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            num_errors++;
            conclude();
        end
    end

    // -----------------------------------------------------------------
    // Comparison and verdict
    // -----------------------------------------------------------------
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic conclude();
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic check_reset();
        chk_bit("shutdown flag", 1'b1, shutdown);
        chk_bit("user mode", 1'b0, user_mode);
        chk_bit("rsp valid", 1'b0, rsp.valid);
    endtask : check_reset

    // Kernel walk over every segment, with two addresses in each.
    task automatic check_map();
        logic [31:0] va_tab [8] = '{32'h0000_0010, 32'h3fff_fffc, 32'h8000_1234,
            32'h9fff_fff0, 32'ha000_0000, 32'hbfff_ff00, 32'hc000_0004, 32'hffef_0000};
        logic [31:0] pa_tab [8] = '{32'h4000_0010, 32'h7fff_fffc, 32'h0000_1234,
            32'h1fff_fff0, 32'h0000_0000, 32'h1fff_ff00, 32'hc000_0004, 32'hffef_0000};
        logic ca_tab [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 8; i++) begin
            core.step(1'b1, va_tab[i], 4'h0);
            chk_bit("rsp valid", 1'b1, rsp.valid);
            chk_word("pa", pa_tab[i], rsp.pa);
            chk_bit("cacheable", ca_tab[i], rsp.cacheable);
            chk_bit("addr err", 1'b0, rsp.addr_err);
            chk_word("vpn", {12'h000, va_tab[i][31:12]}, {12'h000, virtual_page_number});
        end
    endtask : check_map

    task automatic check_cp();
        core.step(1'b0, 32'h0000_0000, 4'h2);
        chk_bit("cp ack wr", 1'b1, cp_ack);
        core.step(1'b0, 32'h0000_0000, 4'h1);
        chk_bit("cp ack rd", 1'b1, cp_ack);
        chk_word("cp rdata", 32'h0000_0000, cp_rdata);
        core.step(1'b1, 32'hc000_1234, 4'h2);
        chk_bit("cp ack wr access", 1'b1, cp_ack);
        chk_word("pa beside cp write", 32'hc000_1234, rsp.pa);
        core.step(1'b0, 32'h0000_0000, 4'h0);
        chk_bit("cp ack idle", 1'b0, cp_ack);
    endtask : check_cp

    // Reset leaves every stack level in kernel; three returns reach user.
    task automatic check_user();
        logic [31:0] va_tab [4] = '{32'h0000_0100, 32'h8000_0000, 32'ha000_0040,
            32'hc000_0000};
        logic er_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
        logic [31:0] pa_tab [4] = '{32'h4000_0100, 32'h0000_0000, 32'h0000_0040,
            32'hc000_0000};
        for (int i = 0; i < 3; i++) begin
            core.step(1'b0, 32'h0000_0000, 4'h4);
            chk_bit("mode after return", (i == 2), user_mode);
        end
        for (int i = 0; i < 4; i++) begin
            core.step(1'b1, va_tab[i], 4'h0);
            chk_bit("user addr err", er_tab[i], rsp.addr_err);
            chk_bit("user cacheable", 1'b0, rsp.cacheable);
            chk_word("user pa", pa_tab[i], rsp.pa);
        end
        // An access beside the exception still sees the user state.
        core.step(1'b1, 32'h8000_1234, 4'h8);
        chk_bit("err with exception", 1'b1, rsp.addr_err);
        chk_bit("mode after exception", 1'b0, user_mode);
        core.step(1'b0, 32'h0000_0000, 4'h4);
        chk_bit("mode after round trip", 1'b1, user_mode);
        core.step(1'b1, 32'hc000_0000, 4'hc);
        chk_bit("mapped seg err", 1'b1, rsp.addr_err);
        chk_bit("mode exc over ret", 1'b0, user_mode);
    endtask : check_user

    initial begin
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check_reset();
        check_map();
        check_cp();
        check_user();
        conclude();
    end
endmodule : tb
`default_nettype wire
